/* File: src/fpa_addsub_core.v */
// Floating-point add/subtract sequencer with status register.
// How it works
// - Single fraction is 23 bits, top bit 22, hidden one above it.
// - Hidden one restored before work, result normalized, hidden one stripped on output.
// - Single: sign at bit 31, 8-bit exponent in bits 23-30, bias 127.
// - Double: 64 bits, sign bit 63, 11-bit exponent bits 52-62, bias 1023.
// - Double fraction is 52 bits, top bit 51, hidden one restored and stripped.
// - Status bits 0 and 4 are reserved and always read zero.
// - Status bit 1 flags exponent overflow during a command.
// - Status bit 2 flags exponent underflow during a command.
// - Status bit 3 flags an attempted division by zero during a command only.
// - Status bit 5 set when the written-back result is all zero bits.
// - Status bit 6 set when the written-back result is negative.
// - Reset leaves every status bit at zero; the clear command does too, except bit 3 on a division by zero during it.
// - Status bit 7 is busy: set on issue, cleared at completion.
// - Issuing a command clears status bits 0 to 6 first.
// - Unpack to 1-bit sign, exponent copied, mantissa with a one prepended.
// - Subtract flips the stack-top sign then runs the add path.
// - Align by right-shifting smaller-exponent mantissa, incrementing its exponent.
// - Result sign and exponent come from the larger-magnitude operand.
// - Like signs: add, shift right once, increment exponent, check overflow.
// - Unlike signs: subtract smaller from larger, left-normalize with decrements.
// - Exponent top bit going 0 to 1 while normalizing sets underflow, ends.
// - Halfway results round to the neighbour with even mantissa LSB.
`timescale 1ns/1ps
`include "fpa_defs.vh"

module fpa_addsub_core #(
  parameter EXP_W = `FPA_SP_EXP_W,
  parameter FRAC_W = `FPA_SP_FRAC_W
) (
  input wire clk_i,
  input wire resetn_i,
  input wire ce_i,
  input wire cmd_valid_i,
  input wire [1:0] cmd_op_i,
  input wire [EXP_W+FRAC_W:0] stack_top_entry_i,
  input wire [EXP_W+FRAC_W:0] second_stack_entry_i,
  input wire div_zero_i,
  output reg cmd_ready_o,
  output reg [EXP_W+FRAC_W:0] result_o,
  output reg result_valid_o,
  output wire [7:0] arith_status_flags_o
);

  // ==========================================================================
  // Widths and states
  localparam W = EXP_W + FRAC_W + 1;
  // Hidden one, fraction, then guard, round and sticky bits.
  localparam MX = FRAC_W + 4;
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ALIGN = 3'h1;
  localparam [2:0] ST_COMBINE = 3'h2;
  localparam [2:0] ST_NORM = 3'h3;
  localparam [2:0] ST_ROUND = 3'h4;
  localparam [2:0] ST_DONE = 3'h5;

  reg [2:0] state_q;
  reg sa_q;
  reg sb_q;
  reg za_q;
  reg zb_q;
  reg [EXP_W-1:0] ea_q;
  reg [EXP_W-1:0] eb_q;
  reg [MX-1:0] ma_q;
  reg [MX-1:0] mb_q;
  reg sr_q;
  reg [EXP_W-1:0] er_q;
  reg [MX-1:0] mr_q;
  reg zres_q;
  reg nores_q;
  reg [1:0] lsh_q;
  reg issue_q;
  reg done_q;
  reg dzero_q;
  reg dneg_q;
  reg ovf_q;
  reg unf_q;

  wire s_t;
  wire s_n;
  wire [EXP_W-1:0] e_t;
  wire [EXP_W-1:0] e_n;
  wire [FRAC_W:0] m_t;
  wire [FRAC_W:0] m_n;
  wire z_t;
  wire z_n;

  // ==========================================================================
  // Operand unpacking
  fpa_unpack #(.EXP_W(EXP_W), .FRAC_W(FRAC_W)) u_unpack_top (
    .word_i(stack_top_entry_i),
    .sign_o(s_t),
    .exp_o(e_t),
    .mant_o(m_t),
    .zero_o(z_t)
  );

  fpa_unpack #(.EXP_W(EXP_W), .FRAC_W(FRAC_W)) u_unpack_second (
    .word_i(second_stack_entry_i),
    .sign_o(s_n),
    .exp_o(e_n),
    .mant_o(m_n),
    .zero_o(z_n)
  );

  // ==========================================================================
  // Datapath terms
  // Op code 3 is dropped here, so it never raises busy or clears the flags.
  wire start_w = cmd_ready_o && cmd_valid_i && (cmd_op_i != `FPA_CMD_NOP);
  wire [MX:0] sum_w = {1'b0, ma_q} + {1'b0, mb_q};
  wire a_big_w = (ma_q >= mb_q);
  wire [MX-1:0] diff_w = a_big_w ? (ma_q - mb_q) : (mb_q - ma_q);
  wire [EXP_W-1:0] ea_inc_w = ea_q + 1'b1;
  wire [EXP_W-1:0] eb_inc_w = eb_q + 1'b1;
  wire [EXP_W-1:0] er_inc_w = er_q + 1'b1;
  wire [EXP_W-1:0] er_dec_w = er_q - 1'b1;
  // Round to nearest even: guard set and either round, sticky or LSB set.
  // Two or more left shifts mean no bits were lost, so rounding is skipped then.
  wire rnd_w = mr_q[2] && (mr_q[1] || mr_q[0] || mr_q[3]) && (lsh_q < 2'h2);
  wire [FRAC_W+1:0] rsum_w = {1'b0, mr_q[MX-1:3]} + {{(FRAC_W+1){1'b0}}, rnd_w};
  wire [W-1:0] packed_w = zres_q ? {W{1'b0}} : {sr_q, er_q, mr_q[MX-2:3]};

  // ==========================================================================
  // Sequencer
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= ST_IDLE;
      sa_q <= 1'b0;
      sb_q <= 1'b0;
      za_q <= 1'b0;
      zb_q <= 1'b0;
      ea_q <= {EXP_W{1'b0}};
      eb_q <= {EXP_W{1'b0}};
      ma_q <= {MX{1'b0}};
      mb_q <= {MX{1'b0}};
      sr_q <= 1'b0;
      er_q <= {EXP_W{1'b0}};
      mr_q <= {MX{1'b0}};
      zres_q <= 1'b0;
      nores_q <= 1'b0;
      lsh_q <= 2'h0;
      issue_q <= 1'b0;
      done_q <= 1'b0;
      dzero_q <= 1'b0;
      dneg_q <= 1'b0;
      ovf_q <= 1'b0;
      unf_q <= 1'b0;
      cmd_ready_o <= 1'b1;
      result_o <= {W{1'b0}};
      result_valid_o <= 1'b0;
    end else if (ce_i) begin
      // Event strobes last one enabled cycle and fall back here unless set below.
      issue_q <= 1'b0;
      done_q <= 1'b0;
      ovf_q <= 1'b0;
      unf_q <= 1'b0;
      result_valid_o <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (start_w) begin
            issue_q <= 1'b1;
            cmd_ready_o <= 1'b0;
            nores_q <= (cmd_op_i == `FPA_CMD_CLEAR);
            zres_q <= 1'b0;
            sa_q <= s_t ^ (cmd_op_i == `FPA_CMD_SUB);
            sb_q <= s_n;
            ea_q <= e_t;
            eb_q <= e_n;
            ma_q <= {m_t, 3'h0};
            mb_q <= {m_n, 3'h0};
            za_q <= z_t;
            zb_q <= z_n;
            // The clear command skips the datapath and reports no result word.
            if (cmd_op_i == `FPA_CMD_CLEAR) begin
              state_q <= ST_DONE;
            end else begin
              state_q <= ST_ALIGN;
            end
          end
        end
        ST_ALIGN: begin
          if (za_q || zb_q) begin
            // A zero operand passes the other one through untouched.
            sr_q <= za_q ? (sb_q & ~zb_q) : sa_q;
            er_q <= za_q ? eb_q : ea_q;
            mr_q <= za_q ? mb_q : ma_q;
            zres_q <= za_q && zb_q;
            state_q <= ST_DONE;
          end else if (ea_q < eb_q) begin
            ma_q <= {1'b0, ma_q[MX-1:2], ma_q[1] | ma_q[0]};
            ea_q <= ea_inc_w;
          end else if (eb_q < ea_q) begin
            mb_q <= {1'b0, mb_q[MX-1:2], mb_q[1] | mb_q[0]};
            eb_q <= eb_inc_w;
          end else begin
            state_q <= ST_COMBINE;
          end
        end
        ST_COMBINE: begin
          lsh_q <= 2'h0;
          sr_q <= a_big_w ? sa_q : sb_q;
          if (sa_q == sb_q) begin
            mr_q <= {sum_w[MX:2], sum_w[1] | sum_w[0]};
            er_q <= ea_inc_w;
            // Overflow does not stop the run; the exponent wraps and only the flag reports it.
            if (ea_q[EXP_W-1] && !ea_inc_w[EXP_W-1]) begin
              ovf_q <= 1'b1;
            end
            state_q <= ST_NORM;
          end else if (diff_w == {MX{1'b0}}) begin
            zres_q <= 1'b1;
            sr_q <= 1'b0;
            state_q <= ST_DONE;
          end else begin
            mr_q <= diff_w;
            er_q <= ea_q;
            state_q <= ST_NORM;
          end
        end
        ST_NORM: begin
          if (mr_q[MX-1]) begin
            state_q <= ST_ROUND;
          end else begin
            // Sticky stays put on left shifts; only guard and round move.
            mr_q <= {mr_q[MX-2:1], 1'b0, mr_q[0]};
            er_q <= er_dec_w;
            if (lsh_q != 2'h2) begin
              lsh_q <= lsh_q + 2'h1;
            end
            // Underflow aborts at once; the packed word then carries the wrapped exponent.
            if (!er_q[EXP_W-1] && er_dec_w[EXP_W-1]) begin
              unf_q <= 1'b1;
              state_q <= ST_DONE;
            end
          end
        end
        ST_ROUND: begin
          if (rsum_w[FRAC_W+1]) begin
            mr_q <= {rsum_w[FRAC_W+1:1], 3'h0};
            er_q <= er_inc_w;
            if (er_q[EXP_W-1] && !er_inc_w[EXP_W-1]) begin
              ovf_q <= 1'b1;
            end
          end else begin
            mr_q <= {rsum_w[FRAC_W:0], 3'h0};
          end
          state_q <= ST_DONE;
        end
        ST_DONE: begin
          done_q <= 1'b1;
          cmd_ready_o <= 1'b1;
          state_q <= ST_IDLE;
          // A clear reports neither zero nor sign, so only bit 3 can end high, if a division by zero arrives during it.
          if (nores_q) begin
            dzero_q <= 1'b0;
            dneg_q <= 1'b0;
          end else begin
            result_o <= packed_w;
            result_valid_o <= 1'b1;
            dzero_q <= (packed_w == {W{1'b0}});
            dneg_q <= packed_w[W-1];
          end
        end
        default: begin
          state_q <= ST_IDLE;
          cmd_ready_o <= 1'b1;
        end
      endcase
    end
  end

  // ==========================================================================
  // Status register
  // Overflow and underflow flags land one cycle after the sequencer event, still before busy drops.
  fpa_status u_status (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .ce_i(ce_i),
    .issue_i(issue_q),
    .done_i(done_q),
    .res_zero_i(dzero_q),
    .res_neg_i(dneg_q),
    .ovf_i(ovf_q),
    .unf_i(unf_q),
    .divx_i(div_zero_i),
    .arith_status_flags_o(arith_status_flags_o)
  );

endmodule

/* File: src/fpa_defs.vh */
// Constants for the floating-point add/subtract core and its status register.
`ifndef FPA_DEFS_VH
`define FPA_DEFS_VH

// ==========================================================================
// Single precision layout
`define FPA_SP_SIGN_BIT 31
`define FPA_SP_EXP_LSB 23
`define FPA_SP_EXP_W 8
`define FPA_SP_FRAC_MSB 22
`define FPA_SP_FRAC_W 23
`define FPA_SP_BIAS 127

// ==========================================================================
// Double precision layout
`define FPA_DP_SIGN_BIT 63
`define FPA_DP_EXP_LSB 52
`define FPA_DP_EXP_W 11
`define FPA_DP_FRAC_MSB 51
`define FPA_DP_FRAC_W 52
`define FPA_DP_BIAS 1023

// ==========================================================================
// Status register fields
`define FPA_ST_RSVD0 0
`define FPA_ST_OVF 1
`define FPA_ST_UNF 2
`define FPA_ST_DIVX 3
`define FPA_ST_RSVD4 4
`define FPA_ST_ZERO 5
`define FPA_ST_SIGN 6
`define FPA_ST_BUSY 7
`define FPA_ST_RESET 8'h00

// ==========================================================================
// Command codes
`define FPA_CMD_ADD 2'h0
`define FPA_CMD_SUB 2'h1
`define FPA_CMD_CLEAR 2'h2
`define FPA_CMD_NOP 2'h3

`endif

/* File: src/fpa_status.v */
// Eight-bit arithmetic status register with busy, sign, zero and exception flags.
`timescale 1ns/1ps
`include "fpa_defs.vh"

module fpa_status (
  input wire clk_i,
  input wire resetn_i,
  input wire ce_i,
  input wire issue_i,
  input wire done_i,
  input wire res_zero_i,
  input wire res_neg_i,
  input wire ovf_i,
  input wire unf_i,
  input wire divx_i,
  output reg [7:0] arith_status_flags_o
);

  reg [7:0] flags_d;

  // ==========================================================================
  // Next value
  always @* begin
    flags_d = arith_status_flags_o;
    if (issue_i) begin
      flags_d = 8'h00;
      flags_d[`FPA_ST_BUSY] = 1'b1;
    end
    if (done_i) begin
      flags_d[`FPA_ST_BUSY] = 1'b0;
      flags_d[`FPA_ST_ZERO] = res_zero_i;
      flags_d[`FPA_ST_SIGN] = res_neg_i;
    end
    // Event sets come last so that they win over the clear at issue.
    if (ovf_i) begin
      flags_d[`FPA_ST_OVF] = 1'b1;
    end
    if (unf_i) begin
      flags_d[`FPA_ST_UNF] = 1'b1;
    end
    if (divx_i && (flags_d[`FPA_ST_BUSY] || done_i)) begin
      flags_d[`FPA_ST_DIVX] = 1'b1;
    end
    flags_d[`FPA_ST_RSVD0] = 1'b0;
    flags_d[`FPA_ST_RSVD4] = 1'b0;
  end

  // ==========================================================================
  // Register
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      arith_status_flags_o <= `FPA_ST_RESET;
    end else if (ce_i) begin
      arith_status_flags_o <= flags_d;
    end
  end

endmodule

/* File: src/fpa_unpack.v */
// Operand unpacker: splits a packed word into sign, exponent and mantissa with hidden one.
`timescale 1ns/1ps
`include "fpa_defs.vh"

module fpa_unpack #(
  parameter EXP_W = `FPA_SP_EXP_W,
  parameter FRAC_W = `FPA_SP_FRAC_W
) (
  input wire [EXP_W+FRAC_W:0] word_i,
  output wire sign_o,
  output wire [EXP_W-1:0] exp_o,
  output wire [FRAC_W:0] mant_o,
  output wire zero_o
);

  // ==========================================================================
  // Field split
  assign sign_o = word_i[EXP_W+FRAC_W];
  assign exp_o = word_i[EXP_W+FRAC_W-1:FRAC_W];
  assign mant_o = {1'b1, word_i[FRAC_W-1:0]};
  // A zero exponent marks a zero operand, so the hidden one must not be trusted there.
  assign zero_o = (exp_o == {EXP_W{1'b0}});

endmodule

/* File: tb/fpa_addsub_core_tb.sv */
// Self-checking bench for the add/subtract core in both precisions.
`timescale 1ns/1ps
`include "fpa_defs.vh"
module fpa_addsub_core_tb;
  reg clk_i = 1'b0;
  reg resetn_i = 1'b1;
  reg ce_i = 1'b1;
  reg div_zero_i = 1'b0;
  reg [15:0] lfsr = 16'hEF7C;
  reg [63:0] dp_seen = 64'h0;
  wire cmd_valid, cmd_ready, res_valid, dp_valid;
  wire [1:0] cmd_op;
  wire [31:0] opa, opb, res;
  wire [7:0] flags;
  wire [63:0] dp_res;
  integer n_mismatch = 0;
  integer n_tests = 0;
  integer i, a, b, r, op;
  always #25 clk_i = ~clk_i;
  // ==========================================================================
  // Expectation helpers
  function [31:0] to_fp(input integer v);
    integer m, p;
    begin
      m = (v < 0) ? -v : v;
      p = 0;
      while ((m >> (p + 1)) != 0) p = p + 1;
      to_fp = (m == 0) ? 32'h00000000 : {v < 0, p[7:0] + 8'h7F, m[22:0] << (23 - p)};
    end
  endfunction
  function [63:0] sp2dp(input [31:0] s);
    sp2dp = (s[30:23] == 8'h00) ? 64'h0 : {s[31], {3'h0, s[30:23]} + 11'h380, s[22:0], 29'h0};
  endfunction
  function [15:0] rnd(input [15:0] s);
    rnd = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // ==========================================================================
  // Design and host
  fpa_host_model u_fpa_host_model (.clk_i(clk_i), .cmd_ready_i(cmd_ready), .cmd_valid_o(cmd_valid),
    .cmd_op_o(cmd_op), .stack_top_entry_o(opa), .second_stack_entry_o(opb));
  fpa_addsub_core u_fpa_addsub_core (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i), .cmd_valid_i(cmd_valid),
    .cmd_op_i(cmd_op), .stack_top_entry_i(opa), .second_stack_entry_i(opb), .div_zero_i(div_zero_i),
    .cmd_ready_o(cmd_ready), .result_o(res), .result_valid_o(res_valid), .arith_status_flags_o(flags));
  fpa_addsub_core #(.EXP_W(11), .FRAC_W(52)) u_fpa_addsub_core_dp (.clk_i(clk_i), .resetn_i(resetn_i),
    .ce_i(ce_i), .cmd_valid_i(cmd_valid), .cmd_op_i(cmd_op), .stack_top_entry_i(sp2dp(opa)),
    .second_stack_entry_i(sp2dp(opb)), .div_zero_i(div_zero_i), .cmd_ready_o(), .result_o(dp_res),
    .result_valid_o(dp_valid), .arith_status_flags_o());
  always @(posedge clk_i) if (dp_valid) dp_seen <= dp_res;
  // ==========================================================================
  // Checking tasks
  task chk(input [127:0] nm, input [63:0] e, input [63:0] g);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("unexpected %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  // The double core sees the same command with widened operands, so a command run with cr set to 3 checks both widths.
  task run(input [1:0] o, input [31:0] t, input [31:0] n, input [31:0] er, input [7:0] ef, input [7:0] fm,
    input [1:0] cr, input dz);
    integer k;
    begin
      u_fpa_host_model.issue(o, t, n);
      if (dz) begin
        repeat (2) @(negedge clk_i);
        div_zero_i = 1'b1;
        @(negedge clk_i);
        div_zero_i = 1'b0;
      end
      k = 0;
      while (o < `FPA_CMD_CLEAR && res_valid !== 1'b1 && k < 700) begin
        @(negedge clk_i);
        k = k + 1;
      end
      if (k >= 700) n_mismatch = n_mismatch + 1;
      if (cr[0]) chk("result", er, res);
      repeat (3) @(negedge clk_i);
      chk("status", ef, flags & fm);
      if (cr[1]) chk("double result", sp2dp(er), dp_seen);
    end
  endtask
  // ==========================================================================
  // Scenarios
  initial begin
    #250000;
    n_mismatch = n_mismatch + 1;
    give_verdict;
  end
  initial begin
    // Reset falls after time zero so that the asynchronous reset branch sees a real edge.
    #1 resetn_i = 1'b0;
    repeat (3) @(negedge clk_i);
    resetn_i = 1'b1;
    chk("idle state", 9'h100, {cmd_ready, flags});
    run(`FPA_CMD_ADD, 32'h3F800000, 32'h3F800000, 32'h40000000, 8'h00, 8'hFF, 2'h3, 1'b0);
    run(`FPA_CMD_SUB, 32'h3F800000, 32'h3F800000, 32'h00000000, 8'h20, 8'hFF, 2'h3, 1'b0);
    run(`FPA_CMD_SUB, 32'h40000000, 32'h3F800000, 32'hBF800000, 8'h40, 8'hFF, 2'h3, 1'b0);
    run(`FPA_CMD_ADD, 32'h33800000, 32'h3F800001, 32'h3F800002, 8'h00, 8'hFF, 2'h1, 1'b0);
    run(`FPA_CMD_ADD, 32'h7F800000, 32'h7F800000, 32'h0, 8'h22, 8'hFF, 2'h0, 1'b0);
    // A reset between commands must wipe the flags that the last command has left set.
    resetn_i = 1'b0;
    @(negedge clk_i);
    resetn_i = 1'b1;
    chk("reset again", 9'h100, {cmd_ready, flags});
    run(`FPA_CMD_SUB, 32'h00800000, 32'h00A00000, 32'h0, 8'h04, 8'hFF, 2'h0, 1'b0);
    run(`FPA_CMD_ADD, 32'h3F800000, 32'h3F800000, 32'h40000000, 8'h08, 8'hFF, 2'h3, 1'b1);
    run(`FPA_CMD_CLEAR, 32'h3F800000, 32'h3F800000, 32'h0, 8'h00, 8'hFF, 2'h0, 1'b0);
    run(`FPA_CMD_NOP, 32'hBF800000, 32'h3F800000, 32'h0, 8'h00, 8'hFF, 2'h0, 1'b0);
    // Clock enable held low mid-command must freeze the sequencer and the flags alike.
    u_fpa_host_model.issue(`FPA_CMD_ADD, 32'h40000000, 32'h3F800000);
    @(negedge clk_i);
    ce_i = 1'b0;
    repeat (8) @(negedge clk_i);
    chk("frozen state", 9'h080, {cmd_ready, flags});
    ce_i = 1'b1;
    i = 0;
    while (res_valid !== 1'b1 && i < 700) begin
      @(negedge clk_i);
      i = i + 1;
    end
    chk("frozen sum", 32'h40400000, res);
    repeat (3) @(negedge clk_i);
    chk("frozen flags", 8'h00, flags);
    for (i = 0; i < 40; i = i + 1) begin
      lfsr = rnd(lfsr);
      a = (lfsr % 511) - 255;
      lfsr = rnd(lfsr);
      b = (lfsr % 511) - 255;
      op = lfsr[15];
      r = op ? b - a : b + a;
      run(op[1:0], to_fp(a), to_fp(b), to_fp(r), {1'b0, r < 0, r == 0, 5'h0}, 8'hFF, 2'h3, 1'b0);
    end
    give_verdict;
  end
endmodule

/* File: tb/fpa_checker.sv */
// Port-level assertions for the add/subtract core.
`timescale 1ns/1ps
`include "fpa_defs.vh"
module fpa_checker #(
  parameter EXP_W = 8,
  parameter FRAC_W = 23
) (
  input wire clk_i,
  input wire resetn_i,
  input wire ce_i,
  input wire cmd_valid_i,
  input wire [1:0] cmd_op_i,
  input wire div_zero_i,
  input wire cmd_ready_o,
  input wire [EXP_W+FRAC_W:0] result_o,
  input wire result_valid_o,
  input wire [7:0] arith_status_flags_o
);
  wire tk;
  wire [7:0] st;
  assign tk = ce_i & cmd_ready_o & cmd_valid_i & (cmd_op_i != `FPA_CMD_NOP);
  assign st = arith_status_flags_o;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  rsvd_zero_a: assert property (st[0] == 1'b0 && st[4] == 1'b0)
    else $error("reserved status bit set");
  busy_on_issue_a: assert property (tk |=> !cmd_ready_o ##1 st[7])
    else $error("busy did not follow issue");
  issue_clear_a: assert property (tk |-> ##2 (st[6:5] == 2'b00 && st[2:1] == 2'b00))
    else $error("flags not cleared on issue");
  busy_end_a: assert property (result_valid_o |-> st[7] ##1 !st[7])
    else $error("busy not dropped after result");
  zero_flag_a: assert property (result_valid_o |=> st[5] == (result_o == '0))
    else $error("zero flag wrong");
  sign_flag_a: assert property (result_valid_o |=> st[6] == result_o[EXP_W+FRAC_W])
    else $error("sign flag wrong");
  divx_cause_a: assert property ($rose(st[3]) |-> $past(div_zero_i) || $past(div_zero_i, 2))
    else $error("divide flag without event");
  ovf_busy_a: assert property ($rose(st[1]) |-> st[7])
    else $error("overflow flag outside command");
  unf_busy_a: assert property ($rose(st[2]) |-> st[7])
    else $error("underflow flag outside command");
  clear_zero_a: assert property (tk && cmd_op_i == `FPA_CMD_CLEAR |-> ##4 st == `FPA_ST_RESET)
    else $error("clear left flags set");
  busy_bound_a: assert property ($rose(st[7]) |-> ##[1:600] !st[7])
    else $error("busy never ended");
  reset_state_a: assert property (@(posedge clk_i) disable iff (1'b0)
    !resetn_i |-> st == `FPA_ST_RESET && cmd_ready_o && !result_valid_o)
    else $error("reset state wrong");
endmodule
bind fpa_addsub_core fpa_checker #(.EXP_W(EXP_W), .FRAC_W(FRAC_W)) u_fpa_checker (.clk_i(clk_i),
  .resetn_i(resetn_i), .ce_i(ce_i), .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i), .div_zero_i(div_zero_i),
  .cmd_ready_o(cmd_ready_o), .result_o(result_o), .result_valid_o(result_valid_o),
  .arith_status_flags_o(arith_status_flags_o));

/* File: tb/fpa_host_model.sv */
// Host-side command driver presenting operands to the core.
`timescale 1ns/1ps
module fpa_host_model (
  input wire clk_i,
  input wire cmd_ready_i,
  output reg cmd_valid_o,
  output reg [1:0] cmd_op_o,
  output reg [31:0] stack_top_entry_o,
  output reg [31:0] second_stack_entry_o
);
  initial begin
    cmd_valid_o = 1'b0;
    cmd_op_o = 2'h3;
    stack_top_entry_o = 32'h00000000;
    second_stack_entry_o = 32'h00000000;
  end
  // Operands are inverted after the issue edge so that a late sample cannot pass unseen.
  task issue(input [1:0] op, input [31:0] a, input [31:0] b);
    begin
      @(negedge clk_i);
      cmd_valid_o = 1'b1;
      cmd_op_o = op;
      stack_top_entry_o = a;
      second_stack_entry_o = b;
      while (cmd_ready_i !== 1'b1) @(negedge clk_i);
      @(negedge clk_i);
      cmd_valid_o = 1'b0;
      stack_top_entry_o = ~a;
      second_stack_entry_o = ~b;
    end
  endtask
endmodule
